// [hdl/clufr_top.v]
`timescale 1ns/10ps
`include "clufr_map.vh"
module clufr_top #(
	parameter IDT_CYCLES = `CLUFR_IDT_CYCLES
) (
	input  wire        clock,
	input  wire        rst_n,
	input  wire [3:0]  addr,
	input  wire [7:0]  wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [7:0]  rdata,
	input  wire        rf_level,
	input  wire [1:0]  rx_scheme,
	input  wire        rx_valid,
	input  wire [7:0]  rx_byte,
	input  wire        rx_end,
	input  wire        tx_ready,
	output reg         tx_valid,
	output reg  [7:0]  tx_byte,
	output reg  [1:0]  tx_coding,
	output reg  [1:0]  tx_ask,
	output reg  [7:0]  bit_period,
	output reg  [1:0]  rx_coding,
	output reg  [1:0]  rx_mode_sel,
	output reg         field_on,
	output reg         load_mod,
	output reg         ext_modem,
	input  wire        sc_in,
	output reg         sc_out
);
	localparam ST_IDLE = 2'h0;
	localparam ST_DATA = 2'h1;
	localparam ST_CRC1 = 2'h2;
	localparam ST_CRC2 = 2'h3;

	reg  [7:0]  ctrl;
	reg  [7:0]  key;
	reg  [7:0]  fifo_mem [0:`CLUFR_FIFO_DEPTH-1];
	reg  [5:0]  wptr;
	reg  [5:0]  rptr;
	reg  [6:0]  level;
	reg  [1:0]  state;
	reg  [15:0] crc;
	reg  [15:0] rx_crc;
	reg         ovf_err;
	reg         unf_err;
	reg         crc_err;
	reg         rx_ok;
	reg         initiator;
	reg         rf_seen;
	reg  [15:0] idle_cnt;
	reg  [7:0]  crypt;
	reg  [3:0]  hdr_cnt;
	wire [1:0]  mode = ctrl[`CLUFR_CTRL_MODE_HI:`CLUFR_CTRL_MODE_LO];
	wire [1:0]  spd  = ctrl[`CLUFR_CTRL_SPD_HI:`CLUFR_CTRL_SPD_LO];
	wire        fifo_full  = (level == 7'h40);
	wire        fifo_empty = (level == 7'h00);
	wire        host_push  = wr && (addr == `CLUFR_REG_FIFO);
	wire        host_pop   = rd && (addr == `CLUFR_REG_FIFO);
	wire        tx_pop     = (state == ST_DATA) && !fifo_empty && (!tx_valid || tx_ready);
	wire        rx_push    = rx_valid && ctrl[`CLUFR_CTRL_RX_EN];
	wire        push = (host_push && !fifo_full) || (rx_push && !host_push && !fifo_full);
	wire        pop  = (host_pop && !fifo_empty) || (tx_pop && !host_pop);
	wire [7:0]  push_data = host_push ? wdata : rx_byte;
	wire        man_crc = (mode != `CLUFR_MODE_14A) && (spd != `CLUFR_SPD_106);
	wire [7:0]  tx_plain = fifo_mem[rptr];
	wire [7:0]  tx_data  = (ctrl[`CLUFR_CTRL_CRYPT] && mode == `CLUFR_MODE_14A) ? tx_plain ^ crypt : tx_plain;

	// Byte update of either CRC flavour
	function [15:0] crc_byte;
		input [15:0] c;
		input [7:0]  d;
		input        msb;
		integer      i;
		reg   [15:0] r;
		begin
			r = c;
			for (i = 0; i < 8; i = i + 1) begin
				if (msb)
					r = ((r[15] ^ d[7-i]) ? ((r << 1) ^ `CLUFR_CRC_MAN_POLY) : (r << 1));
				else
					r = ((r[0] ^ d[i]) ? ((r >> 1) ^ `CLUFR_CRC_14A_POLY) : (r >> 1));
			end
			crc_byte = r;
		end
	endfunction

	// Host FIFO storage and pointers
	always @(posedge clock) begin
		if (push)
			fifo_mem[wptr] <= push_data;
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			wptr    <= 6'h00;
			rptr    <= 6'h00;
			level   <= 7'h00;
			ovf_err <= 1'b0;
			unf_err <= 1'b0;
		end else begin
			if (push)
				wptr <= wptr + 6'h01;
			if (pop)
				rptr <= rptr + 6'h01;
			level <= level + {6'h00, push} - {6'h00, pop};
			// Errors set wins over clear
			if ((host_push || rx_push) && fifo_full)
				ovf_err <= 1'b1;
			else if (wr && addr == `CLUFR_REG_ERR && wdata[0])
				ovf_err <= 1'b0;
			if (host_pop && fifo_empty)
				unf_err <= 1'b1;
			else if (wr && addr == `CLUFR_REG_ERR && wdata[1])
				unf_err <= 1'b0;
		end
	end

	// Control registers
	always @(posedge clock) begin
		if (!rst_n) begin
			ctrl <= `CLUFR_CTRL_RESET;
			key  <= 8'h00;
		end else begin
			if (wr && addr == `CLUFR_REG_CTRL)
				ctrl <= wdata;
			else if (state != ST_IDLE)
				ctrl[`CLUFR_CTRL_TX_GO] <= 1'b0;
			if (wr && addr == `CLUFR_REG_KEY)
				key <= wdata;
		end
	end

	// Transmit sequencer: host bytes then appended CRC
	always @(posedge clock) begin
		if (!rst_n) begin
			state    <= ST_IDLE;
			crc      <= `CLUFR_CRC_MAN_INIT;
			tx_valid <= 1'b0;
			tx_byte  <= 8'h00;
			crypt    <= 8'h00;
			hdr_cnt  <= 4'h0;
		end else begin
			if (tx_valid && tx_ready)
				tx_valid <= 1'b0;
			case (state)
				ST_IDLE: begin
					crypt   <= key;
					hdr_cnt <= 4'h0;
					crc   <= man_crc ? `CLUFR_CRC_MAN_INIT : `CLUFR_CRC_14A_INIT;
					if (ctrl[`CLUFR_CTRL_TX_GO] && (field_on || load_mod || mode == `CLUFR_MODE_NFC_ACT))
						state <= ST_DATA;
				end
				ST_DATA: begin
					if (tx_pop) begin
						tx_valid <= 1'b1;
						tx_byte  <= tx_data;
						crypt    <= {crypt[6:0], crypt[7] ^ crypt[5] ^ crypt[4] ^ crypt[3]};
						// Manchester check value starts at the length byte
						if (hdr_cnt != `CLUFR_MAN_HDR_BYTES)
							hdr_cnt <= hdr_cnt + 4'h1;
						if (!man_crc || hdr_cnt == `CLUFR_MAN_HDR_BYTES)
							crc <= crc_byte(crc, tx_plain, man_crc);
					end else if (fifo_empty && (!tx_valid || tx_ready))
						state <= ST_CRC1;
				end
				ST_CRC1: begin
					if (!tx_valid || tx_ready) begin
						tx_valid <= 1'b1;
						tx_byte  <= man_crc ? crc[15:8] : crc[7:0];
						state    <= ST_CRC2;
					end
				end
				ST_CRC2: begin
					if (!tx_valid || tx_ready) begin
						tx_valid <= 1'b1;
						tx_byte  <= man_crc ? crc[7:0] : crc[15:8];
						state    <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Receive CRC check over every received byte including CRC
	always @(posedge clock) begin
		if (!rst_n) begin
			rx_crc  <= `CLUFR_CRC_MAN_INIT;
			crc_err <= 1'b0;
			rx_ok   <= 1'b0;
		end else begin
			if (!ctrl[`CLUFR_CTRL_RX_EN])
				rx_crc <= man_crc ? `CLUFR_CRC_MAN_INIT : `CLUFR_CRC_14A_INIT;
			else if (rx_end) begin
				rx_crc <= man_crc ? `CLUFR_CRC_MAN_INIT : `CLUFR_CRC_14A_INIT;
				rx_ok  <= (rx_crc == (man_crc ? 16'h0000 : 16'h0000)) ? 1'b1 : 1'b0;
			end else if (rx_push)
				rx_crc <= crc_byte(rx_crc, rx_byte, man_crc);
			if (rx_end && rx_crc != 16'h0000)
				crc_err <= 1'b1;
			else if (wr && addr == `CLUFR_REG_ERR && wdata[2])
				crc_err <= 1'b0;
		end
	end

	// Field control: target by default, initiator after quiet wait
	always @(posedge clock) begin
		if (!rst_n) begin
			initiator <= 1'b0;
			idle_cnt  <= 16'h0000;
			rf_seen   <= 1'b0;
		end else begin
			rf_seen <= rf_level;
			if (!ctrl[`CLUFR_CTRL_INIT_REQ] || rf_level) begin
				idle_cnt <= 16'h0000;
				if (!ctrl[`CLUFR_CTRL_INIT_REQ])
					initiator <= 1'b0;
			end else if (idle_cnt >= IDT_CYCLES[15:0] - 16'h0001)
				initiator <= 1'b1;
			else
				idle_cnt <= idle_cnt + 16'h0001;
		end
	end

	// Coding, modulation and modem selection per mode and speed
	always @(posedge clock) begin
		if (!rst_n) begin
			tx_coding   <= `CLUFR_CODE_MILLER;
			tx_ask      <= `CLUFR_ASK_100;
			bit_period  <= `CLUFR_BIT_106;
			rx_coding   <= `CLUFR_CODE_MANCH;
			rx_mode_sel <= `CLUFR_MODE_14A;
			field_on    <= 1'b0;
			load_mod    <= 1'b0;
			ext_modem   <= 1'b0;
			sc_out      <= 1'b0;
		end else begin
			bit_period <= (spd == `CLUFR_SPD_106) ? `CLUFR_BIT_106 :
			              (spd == `CLUFR_SPD_212) ? `CLUFR_BIT_212 : `CLUFR_BIT_424;
			ext_modem  <= (spd == `CLUFR_SPD_HIGH);
			sc_out     <= (spd == `CLUFR_SPD_HIGH) ? (tx_valid & tx_byte[7]) : sc_in;
			rx_mode_sel <= rx_scheme;
			if (spd == `CLUFR_SPD_HIGH) begin
				tx_coding <= `CLUFR_CODE_EXT;
				tx_ask    <= `CLUFR_ASK_100; // Depth is the external modem's job
				rx_coding <= `CLUFR_CODE_EXT;
			end else if (mode == `CLUFR_MODE_14A) begin
				tx_coding <= `CLUFR_CODE_MILLER;
				tx_ask    <= `CLUFR_ASK_100;
				rx_coding <= (spd == `CLUFR_SPD_106) ? `CLUFR_CODE_MANCH : `CLUFR_CODE_BPSK;
			end else if (mode == `CLUFR_MODE_MAN) begin
				tx_coding <= `CLUFR_CODE_MANCH;
				tx_ask    <= `CLUFR_ASK_8_14;
				rx_coding <= `CLUFR_CODE_MANCH;
			end else begin
				tx_coding <= (spd == `CLUFR_SPD_106) ? `CLUFR_CODE_MILLER : `CLUFR_CODE_MANCH;
				tx_ask    <= (spd == `CLUFR_SPD_106) ? `CLUFR_ASK_100 : `CLUFR_ASK_8_30;
				rx_coding <= (spd == `CLUFR_SPD_106) ? `CLUFR_CODE_MILLER : `CLUFR_CODE_MANCH;
			end
			// Field rules per role
			if (mode == `CLUFR_MODE_NFC_ACT || mode == `CLUFR_MODE_NFC_PAS) begin
				field_on <= initiator || (mode == `CLUFR_MODE_NFC_ACT && state != ST_IDLE);
				load_mod <= !initiator && mode == `CLUFR_MODE_NFC_PAS;
			end else begin
				field_on <= 1'b1;
				load_mod <= 1'b0;
			end
		end
	end

	// Register read port, data one cycle after strobe
	always @(posedge clock) begin
		if (!rst_n)
			rdata <= 8'h00;
		else if (rd) begin
			case (addr)
				`CLUFR_REG_CTRL:   rdata <= ctrl;
				`CLUFR_REG_STATUS: rdata <= {rx_mode_sel, rf_seen, initiator, rx_ok, fifo_full, fifo_empty, state != ST_IDLE};
				`CLUFR_REG_FIFO:   rdata <= fifo_empty ? 8'h00 : fifo_mem[rptr];
				`CLUFR_REG_LEVEL:  rdata <= {1'b0, level};
				`CLUFR_REG_CRC:    rdata <= crc[7:0];
				`CLUFR_REG_ERR:    rdata <= {5'h00, crc_err, unf_err, ovf_err};
				`CLUFR_REG_KEY:    rdata <= key;
				`CLUFR_REG_IDT:    rdata <= {7'h00, rf_level};
				default:           rdata <= 8'h00;
			endcase
		end else
			rdata <= 8'h00;
	end
endmodule // clufr_top

// [hdl/clufr_map.vh]
`ifndef CLUFR_MAP_VH
`define CLUFR_MAP_VH
// Register indices on the plain register port
`define CLUFR_REG_CTRL      4'h0
`define CLUFR_REG_STATUS    4'h1
`define CLUFR_REG_FIFO      4'h2
`define CLUFR_REG_LEVEL     4'h3
`define CLUFR_REG_CRC       4'h4
`define CLUFR_REG_ERR       4'h5
`define CLUFR_REG_KEY       4'h6
`define CLUFR_REG_IDT       4'h7
// Control field positions
`define CLUFR_CTRL_MODE_LO  0
`define CLUFR_CTRL_MODE_HI  1
`define CLUFR_CTRL_SPD_LO   2
`define CLUFR_CTRL_SPD_HI   3
`define CLUFR_CTRL_TX_GO    4
`define CLUFR_CTRL_INIT_REQ 5
`define CLUFR_CTRL_CRYPT    6
`define CLUFR_CTRL_RX_EN    7
`define CLUFR_CTRL_RESET    8'h00
// Modes
`define CLUFR_MODE_14A      2'h0
`define CLUFR_MODE_MAN      2'h1
`define CLUFR_MODE_NFC_ACT  2'h2
`define CLUFR_MODE_NFC_PAS  2'h3
// Speeds
`define CLUFR_SPD_106       2'h0
`define CLUFR_SPD_212       2'h1
`define CLUFR_SPD_424       2'h2
`define CLUFR_SPD_HIGH      2'h3
// Bit periods in carrier cycles
`define CLUFR_BIT_106       8'h80
`define CLUFR_BIT_212       8'h40
`define CLUFR_BIT_424       8'h20
`define CLUFR_SUBCARRIER_DIV 8'h10
// Coding selections
`define CLUFR_CODE_MILLER   2'h0
`define CLUFR_CODE_MANCH    2'h1
`define CLUFR_CODE_BPSK     2'h2
`define CLUFR_CODE_EXT      2'h3
// Modulation depth selections
`define CLUFR_ASK_100       2'h0
`define CLUFR_ASK_8_14      2'h1
`define CLUFR_ASK_8_30      2'h2
`define CLUFR_ASK_LOAD      2'h3
// CRC constants
`define CLUFR_CRC_MAN_INIT  16'h0000
`define CLUFR_CRC_MAN_POLY  16'h1021
`define CLUFR_CRC_14A_INIT  16'h6363
`define CLUFR_CRC_14A_POLY  16'h8408
// Preamble plus sync bytes that the Manchester check value skips
`define CLUFR_MAN_HDR_BYTES 4'h8
// FIFO
`define CLUFR_FIFO_DEPTH    64
`define CLUFR_FIFO_AW       6
// Initial field wait time
`define CLUFR_IDT_US        5
`define CLUFR_CLK_MHZ       100
`define CLUFR_IDT_CYCLES    (`CLUFR_IDT_US * `CLUFR_CLK_MHZ)
`endif

// [verif/clufr_props_properties.sv]
`timescale 1ns/10ps
`include "clufr_map.vh"
module clufr_props (
	input wire		clock,
	input wire		rst_n,
	input wire		rd,
	input wire [7:0]	rdata,
	input wire		tx_ready,
	input wire		tx_valid,
	input wire [7:0]	tx_byte,
	input wire [1:0]	tx_coding,
	input wire [1:0]	tx_ask,
	input wire [7:0]	bit_period,
	input wire		field_on,
	input wire		load_mod
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Coding, depth and period stay consistent
	property p_miller; tx_coding == `CLUFR_CODE_MILLER |-> tx_ask == `CLUFR_ASK_100; endproperty
	a_miller: assert property (p_miller) else $error("miller without full ask");
	property p_period; bit_period == 8'h80 || bit_period == 8'h40 || bit_period == 8'h20; endproperty
	a_period: assert property (p_period) else $error("bad bit period");
	property p_light; tx_ask == `CLUFR_ASK_8_14 |-> tx_coding == `CLUFR_CODE_MANCH && bit_period != 8'h80; endproperty
	a_light: assert property (p_light) else $error("light ask misuse");
	property p_nfc; tx_ask == `CLUFR_ASK_8_30 |-> tx_coding == `CLUFR_CODE_MANCH && bit_period != 8'h80; endproperty
	a_nfc: assert property (p_nfc) else $error("nfc ask misuse");
	// Held byte waits for the modem
	property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte); endproperty
	a_hold: assert property (p_hold) else $error("tx byte dropped");
	property p_rdata; !$past(rd) |-> rdata == 8'h00; endproperty
	a_rdata: assert property (p_rdata) else $error("rdata without read");
	property p_reset; $rose(rst_n) |-> bit_period == 8'h80 && !field_on && !tx_valid; endproperty
	a_reset: assert property (p_reset) else $error("bad reset state");
	property p_load; load_mod |-> !field_on; endproperty
	a_load: assert property (p_load) else $error("load mod with own field");
endmodule // clufr_props
bind clufr_top clufr_props chk_i (.clock(clock), .rst_n(rst_n), .rd(rd), .rdata(rdata), .tx_ready(tx_ready),
	.tx_valid(tx_valid), .tx_byte(tx_byte), .tx_coding(tx_coding), .tx_ask(tx_ask), .bit_period(bit_period),
	.field_on(field_on), .load_mod(load_mod));

// [verif/clufr_peer.sv]
`timescale 1ns/10ps
module clufr_peer (
	input wire		clock,
	input wire		stall,
	input wire		tx_valid,
	input wire [7:0]	tx_byte,
	output reg		tx_ready,
	output reg		rx_valid,
	output reg [7:0]	rx_byte,
	output reg		rx_end
);
	reg [7:0]	got [0:15];
	integer		n = 0;
	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		rx_end = 1'b0;
	end
	// Collect sent bytes, pausing every other cycle when slow
	always @(posedge clock) begin
		if (tx_valid && tx_ready && n < 16) begin
			got[n] <= tx_byte;
			n <= n + 1;
		end
		tx_ready <= stall ? !tx_ready : 1'b1;
	end
	// One reply byte; the data line toggles once released
	task send(input [7:0] b, input last);
		begin
			@(posedge clock);
			rx_valid <= 1'b1;
			rx_byte <= b;
			@(posedge clock);
			rx_valid <= 1'b0;
			rx_byte <= ~b;
			rx_end <= last;
			@(posedge clock);
			rx_end <= 1'b0;
		end
	endtask
endmodule // clufr_peer

// [verif/tb.sv]
`timescale 1ns/10ps
module tb;
	reg		clock = 1'b0;
	reg		rst_n = 1'b0;
	reg		wr = 1'b0;
	reg		rd = 1'b0;
	reg		rf_level = 1'b0;
	reg		sc_in = 1'b1;
	reg		stall = 1'b0;
	reg [3:0]	addr = 4'h0;
	reg [7:0]	wdata = 8'h00;
	reg [1:0]	rx_scheme = 2'h0;
	reg [7:0]	r;
	reg [17:0]	row [0:6];
	wire [7:0]	rdata, tx_byte, bit_period, rx_byte;
	wire [1:0]	tx_coding, tx_ask, rx_coding, rx_mode_sel;
	wire		rx_valid, rx_end, tx_ready, tx_valid, field_on, load_mod, ext_modem, sc_out;
	integer		err_total = 0;
	integer		checks_done = 0;
	integer		i, k;
	always #5 clock = ~clock;
	clufr_top #(.IDT_CYCLES(8)) dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .rf_level(rf_level), .rx_scheme(rx_scheme), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .rx_end(rx_end), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
		.tx_coding(tx_coding), .tx_ask(tx_ask), .bit_period(bit_period), .rx_coding(rx_coding),
		.rx_mode_sel(rx_mode_sel), .field_on(field_on), .load_mod(load_mod), .ext_modem(ext_modem),
		.sc_in(sc_in), .sc_out(sc_out));
	clufr_peer p (.clock(clock), .stall(stall), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end));
	// Frame: six zero bytes, sync, length, data, check value
	function [7:0] fb(input integer j);
		reg [55:0] t;
		begin
			t = 56'hB24D03ABCD9035;
			fb = (j < 6) ? 8'h00 : t[55 - 8 * (j - 6) -: 8];
		end
	endfunction
	task chk(input [7:0] s, input [7:0] e);
		begin
			checks_done = checks_done + 1;
			if (s !== e) begin
				err_total = err_total + 1;
				$display("mismatch at %0t: seen %h expected %h", $time, s, e);
			end
		end
	endtask
	task wreg(input [3:0] a, input [7:0] d);
		begin
			@(posedge clock);
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge clock);
			wr <= 1'b0;
		end
	endtask
	task rreg(input [3:0] a, output [7:0] d);
		begin
			@(posedge clock);
			addr <= a;
			rd <= 1'b1;
			@(posedge clock);
			rd <= 1'b0;
			#1 d = rdata;
		end
	endtask
	task end_of_test;
		begin
			$display("checks %0d errors %0d", checks_done, err_total);
			if (err_total == 0 && checks_done > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	// Rows: mode, speed, tx coding, depth, rx coding, period
	initial begin
		row[0] = {2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 8'h80};
		row[1] = {2'h0, 2'h1, 2'h0, 2'h0, 2'h2, 8'h40};
		row[2] = {2'h0, 2'h2, 2'h0, 2'h0, 2'h2, 8'h20};
		row[3] = {2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 8'h40};
		row[4] = {2'h1, 2'h2, 2'h1, 2'h1, 2'h1, 8'h20};
		row[5] = {2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 8'h80};
		row[6] = {2'h2, 2'h2, 2'h1, 2'h2, 2'h1, 8'h20};
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		#1 chk({6'h00, rx_coding}, 8'h01);
		chk({7'h00, field_on}, 8'h00);
		rreg(4'h2, r);
		rreg(4'h5, r);
		chk(r, 8'h02);
		wreg(4'h5, 8'h02);
		for (i = 0; i < 7; i = i + 1) begin
			wreg(4'h0, {4'h0, row[i][15:14], row[i][17:16]});
			repeat (3) @(posedge clock);
			#1 chk({6'h00, tx_coding}, {6'h00, row[i][13:12]});
			chk({6'h00, tx_ask}, {6'h00, row[i][11:10]});
			chk({6'h00, rx_coding}, {6'h00, row[i][9:8]});
			chk(bit_period, row[i][7:0]);
		end
		chk({7'h00, sc_out}, 8'h01);
		wreg(4'h0, 8'h0C);
		rf_level <= 1'b1;
		rx_scheme <= 2'h2;
		repeat (3) @(posedge clock);
		#1 chk({7'h00, ext_modem}, 8'h01);
		rreg(4'h1, r);
		chk({5'h00, r[7:5]}, 8'h05);
		rf_level <= 1'b0;
		// Host frame out through a slow modem; check appended
		for (k = 0; k < 11; k = k + 1) wreg(4'h2, fb(k));
		stall <= 1'b1;
		wreg(4'h0, 8'h35);
		for (i = 0; i < 3000 && p.n < 13; i = i + 1) @(posedge clock);
		if (p.n < 13) begin
			err_total = err_total + 1;
			end_of_test;
		end
		for (k = 0; k < 13; k = k + 1) chk(p.got[k], fb(k));
		chk({7'h00, field_on}, 8'h01);
		// Good reply, then one with a corrupt check value
		wreg(4'h0, 8'h85);
		for (k = 8; k < 13; k = k + 1) p.send(fb(k), k == 12);
		rreg(4'h1, r);
		chk({7'h00, r[3]}, 8'h01);
		for (k = 8; k < 13; k = k + 1) p.send((k == 12) ? 8'h36 : fb(k), k == 12);
		rreg(4'h5, r);
		chk({7'h00, r[2]}, 8'h01);
		end_of_test;
	end
endmodule // tb
